// File: hw/vih_map.svh
// constants for the vectored interrupt handler
`ifndef VIH_MAP_SVH
`define VIH_MAP_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define VIH_NSRC 22
`define VIH_NPERIPH 12
`define VIH_NEXT 10
`define VIH_IDXW 5
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define VIH_A_PEND 6'h00
`define VIH_A_SWSET 6'h04
`define VIH_A_CLR 6'h08
`define VIH_A_EN 6'h0C
`define VIH_A_GEN 6'h10
`define VIH_A_PRIO 6'h14
`define VIH_A_AUTOCLR 6'h18
`define VIH_A_STAT 6'h1C
`define VIH_A_IRQ 6'h20
`define VIH_A_MASK 6'h24
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define VIH_GEN_BIT 7
`define VIH_RST_EN 22'h000000
`define VIH_RST_PRIO 22'h000000
`define VIH_RST_AUTOCLR 22'h000000
`define VIH_VEC_BASE 16'h0003
`define VIH_VEC_SHIFT 3
`define VIH_CALL_CYC 3'h4
`define VIH_EV_TAKE 0
`define VIH_EV_RET 1
`define VIH_EV_PEND 2
`endif

// File: hw/vih_pkg.sv
// types for the vectored interrupt handler
package vih_pkg;
  typedef logic [21:0] vih_src_t;
  typedef logic [4:0] vih_idx_t;
  typedef logic [15:0] vih_vec_t;
  typedef enum logic [1:0] {VIH_IDLE, VIH_CALL, VIH_WAIT} vih_state_e;
endpackage

// File: hw/vih_pick.sv
// lowest-index picker over the request vector
`timescale 1ns/1ps
`include "vih_map.svh"
module vih_pick (
  // requests
  input wire logic [21:0] req_i,
  // result
  output logic any_o,
  output logic [4:0] idx_o
);
  always_comb begin
    any_o = 1'b0;
    idx_o = 5'h00;
    for (int i = `VIH_NSRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = i[4:0];
      end
    end
  end
endmodule // vih_pick

// File: hw/vih_top.sv
// vectored interrupt handler with wishbone registers
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "vih_map.svh"
module vih_top
  import vih_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // source conditions, one-cycle pulses on clk_i
  input wire logic [11:0] periph_ev_i,
  input wire logic [9:0] ext_ev_i,
  // core sequencer
  input wire logic instr_done_i,
  input wire logic call_ack_i,
  input wire logic ret_done_i,
  output logic core_req_o,
  output logic call_o,
  output vih_pkg::vih_vec_t vec_o,
  output logic [4:0] svc_idx_o,
  output logic in_high_o,
  output logic in_low_o,
  // interrupt
  output logic irq_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  vih_src_t pend;
  vih_src_t en;
  vih_src_t prio;
  vih_src_t autoclr;
  logic gen;
  logic [2:0] stat;
  logic [2:0] mask;
  vih_state_e state;
  logic [2:0] call_cnt;
  logic act_hi;
  logic act_lo;
  vih_idx_t lo_idx;
  vih_idx_t cur_idx;
  logic cur_hi;
  logic ret_flag;
  vih_src_t src_ev;
  vih_src_t ena_req;
  vih_src_t hi_req;
  vih_src_t lo_req;
  logic hi_any;
  logic lo_any;
  vih_idx_t hi_idx;
  vih_idx_t lo_pick;
  logic eligible;
  logic take;
  logic wr;
  logic rd;
  logic wr_lo;
  logic [31:0] next_dat;

  // writes land at the edge where the master samples ack high
  assign wr = cyc_i & stb_i & we_i & ack_o;
  assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
  assign wr_lo = wr & sel_i[0];
  assign src_ev = {ext_ev_i, periph_ev_i};

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  assign ena_req = (gen ? en : 22'h000000) & pend;
  assign hi_req = ena_req & prio;
  assign lo_req = ena_req & ~prio;

  vih_pick u_hi (
    .req_i(hi_req),
    .any_o(hi_any),
    .idx_o(hi_idx)
  );

  vih_pick u_lo (
    .req_i(lo_req),
    .any_o(lo_any),
    .idx_o(lo_pick)
  );

  // high routine blocks all; low routine blocks only other lows
  assign eligible = (state == VIH_IDLE) & ~act_hi & (hi_any | (lo_any & ~act_lo));
  assign core_req_o = eligible;
  assign take = eligible & instr_done_i;

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 22'h000000;
    end else begin
      vih_src_t set_v;
      vih_src_t clr_v;
      set_v = src_ev;
      clr_v = 22'h000000;
      if (wr && adr_i == `VIH_A_SWSET) begin
        set_v = set_v | dat_i[21:0];
      end
      if (wr && adr_i == `VIH_A_CLR) begin
        clr_v = dat_i[21:0];
      end
      if (state == VIH_CALL && call_cnt == 3'h0 && autoclr[cur_idx]) begin
        clr_v[cur_idx] = 1'b1;
      end
      pend <= (pend & ~clr_v) | set_v;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en <= `VIH_RST_EN;
      prio <= `VIH_RST_PRIO;
      autoclr <= `VIH_RST_AUTOCLR;
      gen <= 1'b0;
      mask <= 3'h0;
    end else if (wr) begin
      case (adr_i)
        `VIH_A_EN: en <= dat_i[21:0];
        `VIH_A_PRIO: prio <= dat_i[21:0];
        `VIH_A_AUTOCLR: autoclr <= dat_i[21:0];
        `VIH_A_GEN: if (wr_lo) gen <= dat_i[`VIH_GEN_BIT];
        `VIH_A_MASK: mask <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // call sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= VIH_IDLE;
      call_cnt <= 3'h0;
      cur_idx <= 5'h00;
      cur_hi <= 1'b0;
      call_o <= 1'b0;
      vec_o <= 16'h0000;
    end else begin
      case (state)
        VIH_IDLE: begin
          if (take) begin
            cur_hi <= hi_any;
            cur_idx <= hi_any ? hi_idx : lo_pick;
            vec_o <= `VIH_VEC_BASE
              + ({11'h000, hi_any ? hi_idx : lo_pick} << `VIH_VEC_SHIFT);
            call_cnt <= `VIH_CALL_CYC - 3'h1;
            call_o <= 1'b1;
            state <= VIH_CALL;
          end
        end
        VIH_CALL: begin
          // four cycles of long call complete the five-cycle response
          if (call_cnt == 3'h0) begin
            call_o <= 1'b0;
            state <= VIH_WAIT;
          end else begin
            call_cnt <= call_cnt - 3'h1;
          end
        end
        VIH_WAIT: begin
          if (call_ack_i) begin
            state <= VIH_IDLE;
          end
        end
        default: state <= VIH_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // active level tracking
  // ----------------------------------------
  // one nested level deep: only a low routine can be preempted, by a high one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_hi <= 1'b0;
      act_lo <= 1'b0;
      lo_idx <= 5'h00;
      ret_flag <= 1'b0;
    end else begin
      ret_flag <= 1'b0;
      if (state == VIH_WAIT && call_ack_i) begin
        if (cur_hi) begin
          act_hi <= 1'b1;
        end else begin
          act_lo <= 1'b1;
          lo_idx <= cur_idx;
        end
      end else if (ret_done_i) begin
        ret_flag <= 1'b1;
        if (act_hi) begin
          act_hi <= 1'b0;
        end else begin
          act_lo <= 1'b0;
        end
      end
    end
  end

  assign in_high_o = act_hi;
  assign in_low_o = act_lo;
  assign svc_idx_o = act_hi ? cur_idx : lo_idx;

  // ----------------------------------------
  // event status and interrupt
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= 3'h0;
    end else begin
      logic [2:0] ev;
      ev = 3'h0;
      ev[`VIH_EV_TAKE] = take;
      ev[`VIH_EV_RET] = ret_flag;
      ev[`VIH_EV_PEND] = |src_ev;
      // set wins over the read-clear
      if (rd && adr_i == `VIH_A_STAT) begin
        stat <= ev;
      end else begin
        stat <= stat | ev;
      end
    end
  end

  assign irq_o = |(stat & mask);

  // ----------------------------------------
  // wishbone read and ack
  // ----------------------------------------
  always_comb begin
    next_dat = 32'h00000000;
    case (adr_i)
      `VIH_A_PEND: next_dat = {10'h000, pend};
      `VIH_A_EN: next_dat = {10'h000, en};
      `VIH_A_GEN: next_dat = {24'h000000, gen, 7'h00};
      `VIH_A_PRIO: next_dat = {10'h000, prio};
      `VIH_A_AUTOCLR: next_dat = {10'h000, autoclr};
      `VIH_A_STAT: next_dat = {29'h00000000, stat};
      `VIH_A_IRQ: next_dat = {22'h000000, act_hi, act_lo, 3'h0, cur_idx};
      `VIH_A_MASK: next_dat = {29'h00000000, mask};
      default: next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rd ? next_dat : 32'h00000000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_GEN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !gen |-> !core_req_o) else $error("request with global enable off");
  AST_EN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (ena_req == 22'h000000) |-> !core_req_o) else $error("request with no enabled flag");
  AST_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    src_ev[3] |=> pend[3]) else $error("source 3 flag not set");
  AST_CALL_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(call_o) |-> call_o [*4] ##1 !call_o) else $error("long call not four cycles");
  AST_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(call_o) |-> vec_o == 16'h0003 + {8'h00, cur_idx, 3'h0}) else $error("bad vector");
  AST_NO_PREEMPT_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    act_hi |-> !core_req_o) else $error("high routine preempted");
  AST_TIE: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !hi_any && lo_req[2] && lo_req[1:0] == 2'h0) |=> cur_idx == 5'h02)
    else $error("tie not lowest index");
  AST_SWSET: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == `VIH_A_SWSET && dat_i[21]) |=> pend[21]) else $error("soft set lost");
  AST_STAT_TAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> stat[`VIH_EV_TAKE]) else $error("call event not recorded");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h00000000) else $error("read data outside ack");
  AST_HI_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hi_any) |=> cur_hi) else $error("high request not served first");
  AST_LO_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (act_lo && !hi_any) |-> !core_req_o) else $error("low routine preempted by low");
  AST_RET_POP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ret_done_i && act_hi && !(state == VIH_WAIT && call_ack_i)) |=> !act_hi)
    else $error("return did not end high routine");
  AST_HOLD_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
    (call_o && !$rose(call_o)) |-> $stable(vec_o)) else $error("vector moved in call");
  AST_IN_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == VIH_WAIT && call_ack_i && !cur_hi) |=> in_low_o)
    else $error("low routine not marked active");
  AST_PEND_ANY: assert property (@(posedge clk_i) disable iff (rst_i)
    (|src_ev) |=> (|pend)) else $error("source event left no flag");
  AST_RESET: assert property (@(posedge clk_i)
    rst_i |=> (pend == 22'h000000 && !gen && !core_req_o)) else $error("reset state bad");

  COV_TAKE: cover property (@(posedge clk_i) disable iff (rst_i) take);
  COV_PREEMPT: cover property (@(posedge clk_i) disable iff (rst_i) act_lo && take && hi_any);
  COV_REENTER: cover property (@(posedge clk_i) disable iff (rst_i) ret_flag ##[1:20] take);
  COV_HI_TAKE: cover property (@(posedge clk_i) disable iff (rst_i) take && hi_any);
  COV_AUTOCLR: cover property (@(posedge clk_i) disable iff (rst_i)
    state == VIH_CALL && call_cnt == 3'h0 && autoclr[cur_idx]);
endmodule // vih_top

// File: verif/vih_core_model.sv
// core sequencer model facing the interrupt handler
`timescale 1ns/1ps
module vih_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from handler and bench
  input wire logic call_i,
  input wire logic slow_i,
  input wire logic ret_req_i,
  // to handler
  output logic instr_done_o,
  output logic call_ack_o,
  output logic ret_done_o
);
  logic call_q;
  logic [1:0] tick;
  // --------------------------------
  // instruction stream
  // --------------------------------
  // slowed core ends an instruction only every fourth cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick <= 2'h0;
      instr_done_o <= 1'h0;
    end else begin
      tick <= tick + 2'h1;
      instr_done_o <= !slow_i || (tick == 2'h3);
    end
  end
  // --------------------------------
  // routine entry and return
  // --------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      call_q <= 1'h0;
      call_ack_o <= 1'h0;
      ret_done_o <= 1'h0;
    end else begin
      call_q <= call_i;
      call_ack_o <= call_q && !call_i;
      ret_done_o <= ret_req_i;
    end
  end
endmodule // vih_core_model

// File: verif/tb.sv
// self-checking bench for the vectored interrupt handler
`timescale 1ns/1ps
`include "vih_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("unexpected %0t got %0h want %0h", $time, (a), (e)); end end
module tb;
  import vih_pkg::*;
  // --------------------------------
  // signals
  // --------------------------------
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, slow, ret_req;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic instr_done_i, call_ack_i, ret_done_i, core_req_o, call_o, in_high_o, in_low_o;
  vih_vec_t vec_o;
  logic [4:0] svc_idx_o;
  logic [11:0] periph_ev_i;
  logic [9:0] ext_ev_i;
  int bad_count, cmp_count;
  int tie_idx [3] = '{2, 5, 20};
  logic [5:0] rst_regs [4] = '{`VIH_A_PEND, `VIH_A_EN, `VIH_A_GEN, `VIH_A_PRIO};
  vih_top u_vih_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .periph_ev_i, .ext_ev_i, .instr_done_i, .call_ack_i, .ret_done_i, .core_req_o,
    .call_o, .vec_o, .svc_idx_o, .in_high_o, .in_low_o, .irq_o);
  vih_core_model u_vih_core_model (.clk_i, .rst_i, .call_i(call_o), .slow_i(slow),
    .ret_req_i(ret_req), .instr_done_o(instr_done_i), .call_ack_o(call_ack_i),
    .ret_done_o(ret_done_i));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i) n++; while (ack_o !== 1'h1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (n >= 50) begin
      bad_count++;
      finish_test();
    end
    @(posedge clk_i);
  endtask
  task automatic ev(input logic [21:0] m);
    periph_ev_i <= m[11:0];
    ext_ev_i <= m[21:12];
    @(posedge clk_i);
    periph_ev_i <= 12'h000;
    ext_ev_i <= 10'h000;
    @(posedge clk_i);
  endtask
  task automatic take(input logic [15:0] v, input logic hi);
    int n;
    int k;
    n = 0;
    k = 0;
    do @(posedge clk_i) n++; while (call_o !== 1'h1 && n < 300);
    `CHK(vec_o, v)
    do @(posedge clk_i) k++; while (call_o === 1'h1 && k < 9);
    `CHK(k, 4)
    do @(posedge clk_i) n++; while ((hi ? in_high_o : in_low_o) !== 1'h1 && n < 600);
    if (n >= 600) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge clk_i);
      `CHK(call_o, 1'h0)
    end
  endtask
  task automatic ret();
    ret_req <= 1'h1;
    @(posedge clk_i);
    ret_req <= 1'h0;
    @(posedge clk_i);
  endtask
  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // hard stop in case any handshake hangs
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, slow, ret_req} = 6'h20;
    {adr_i, dat_i, periph_ev_i, ext_ev_i} = '0;
    sel_i = 4'hF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    `CHK(core_req_o, 1'h0)
    for (int i = 0; i < 4; i++) begin
      wb(1'h0, rst_regs[i], 32'h0);
      `CHK(rd, 32'h0)
    end
    ev(22'h000008);
    wb(1'h0, `VIH_A_PEND, 32'h0);
    `CHK(rd, 32'h8)
    quiet(10);
    wb(1'h1, `VIH_A_EN, 32'h8);
    quiet(10);
    slow <= 1'h1;
    wb(1'h1, `VIH_A_GEN, 32'h80);
    take(16'h001B, 1'h0);
    slow <= 1'h0;
    `CHK(svc_idx_o, 5'h03)
    ret();
    take(16'h001B, 1'h0);
    wb(1'h1, `VIH_A_CLR, 32'h8);
    ret();
    quiet(10);
    `CHK(in_low_o, 1'h0)
    `CHK(irq_o, 1'h0)
    wb(1'h1, `VIH_A_MASK, 32'h1);
    `CHK(irq_o, 1'h1)
    wb(1'h0, `VIH_A_STAT, 32'h0);
    `CHK(rd[0], 1'h1)
    `CHK(irq_o, 1'h0)
    wb(1'h1, `VIH_A_AUTOCLR, 32'h200000);
    wb(1'h1, `VIH_A_EN, 32'h200000);
    wb(1'h1, `VIH_A_SWSET, 32'h200000);
    take(16'h00AB, 1'h0);
    wb(1'h0, `VIH_A_PEND, 32'h0);
    `CHK(rd, 32'h0)
    ret();
    // same-level ties resolve lowest index first, one per return
    wb(1'h1, `VIH_A_GEN, 32'h0);
    ev(22'h100024);
    wb(1'h1, `VIH_A_EN, 32'h100024);
    quiet(10);
    wb(1'h1, `VIH_A_GEN, 32'h80);
    for (int i = 0; i < 3; i++) begin
      take(16'(3 + 8 * tie_idx[i]), 1'h0);
      wb(1'h1, `VIH_A_CLR, 32'h1 << tie_idx[i]);
      ret();
    end
    wb(1'h1, `VIH_A_PRIO, 32'h280);
    wb(1'h1, `VIH_A_EN, 32'h284);
    ev(22'h000004);
    take(16'h0013, 1'h0);
    ev(22'h000080);
    take(16'h003B, 1'h1);
    ev(22'h000200);
    quiet(20);
    wb(1'h1, `VIH_A_CLR, 32'h84);
    ret();
    take(16'h004B, 1'h1);
    wb(1'h1, `VIH_A_CLR, 32'h200);
    ret();
    ret();
    quiet(10);
    `CHK({in_high_o, in_low_o}, 2'h0)
    finish_test();
  end
endmodule // tb
